// ---- tb/ilc_capture_checker.sv ----
`timescale 1ns/10ps
module ilc_capture_checker
	import ilc_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RST_B_IN,
	input wire logic CE_IN,
	// Serial port
	input wire ilc_spi_t SPI_IN,
	input wire logic SDO_OUT,
	input wire logic SDO_OE_OUT
);
	logic sclk_r;
	logic [5:0] rises_r;
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	// Counts rises as the port does, so a frame slip of one bit shows up
	always_ff @(posedge CORE_CLK_IN)
	begin
		sclk_r <= SPI_IN.sclk;
		if (!RST_B_IN || SPI_IN.cs_b)
			rises_r <= 6'h00;
		else if (CE_IN && SPI_IN.sclk && !sclk_r)
			rises_r <= rises_r + 6'h01;
	end
	reset_clear_a: assert property (@(posedge CORE_CLK_IN) disable iff (1'b0)
		!RST_B_IN && CE_IN |=> !SDO_OE_OUT && !SDO_OUT) else $error("output not cleared");
	idle_quiet_a: assert property ((SPI_IN.cs_b && CE_IN) [*3] |-> !SDO_OE_OUT)
		else $error("driven while deselected");
	freeze_hold_a: assert property (!CE_IN |=> $stable(SDO_OUT) && $stable(SDO_OE_OUT))
		else $error("moved while disabled");
	bit_count_a: assert property ($rose(SDO_OE_OUT) |-> rises_r == 6'h10)
		else $error("drive not after 16 rises");
	drive_start_a: assert property ($rose(SDO_OE_OUT) |-> $past(SPI_IN.sclk) && !SPI_IN.cs_b)
		else $error("drive start misplaced");
	shift_edge_a: assert property (
		SDO_OE_OUT && $past(SDO_OE_OUT) && $changed(SDO_OUT) |-> !$past(SPI_IN.sclk))
		else $error("data moved off falling clock");
	drive_end_a: assert property (
		$fell(SDO_OE_OUT) |-> !$past(SPI_IN.sclk) || $past(SPI_IN.cs_b))
		else $error("drive ended early");
	drive_hold_a: assert property (
		$rose(SDO_OE_OUT) && SPI_IN.sclk && !SPI_IN.cs_b |=> SDO_OE_OUT)
		else $error("drive dropped at once");
endmodule : ilc_capture_checker

bind ilc_capture ilc_capture_checker i_ilc_capture_checker (
	.CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN), .CE_IN(CE_IN),
	.SPI_IN(SPI_IN), .SDO_OUT(SDO_OUT), .SDO_OE_OUT(SDO_OE_OUT));

// ---- tb/ilc_capture_test.sv ----
`timescale 1ns/10ps
module ilc_capture_test;
	import ilc_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic mode = 1'b1;
	logic go = 1'b0;
	ilc_spi_t spi = '{sclk: 1'b0, cs_b: 1'b1, sdi: 1'b0};
	ilc_oct_arr_t cfg = '0;
	logic [7:0] lid = 8'h00;
	ilc_lane_t lane0;
	ilc_lane_t lane1;
	logic busy;
	logic sdo;
	logic sdo_oe;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int mdl[int];
	always #50 clk = ~clk;
	// Both checksum methods are used; the sender follows the same mode
	ilc_capture i_ilc_capture (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
		.LANE0_IN(lane0), .LANE1_IN(lane1), .CHECKSUM_MODE_IN(mode), .SPI_IN(spi),
		.SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe));
	ilc_tx_model i_ilc_tx_model (.clk_in(clk), .go_in(go), .cfg_in(cfg), .lid_in(lid),
		.lane0_out(lane0), .lane1_out(lane1), .busy_out(busy));
	task automatic finish_test();
		$display("Checks %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	function automatic logic [7:0] fmask(int a);
		case (a)
			'h403, 'h40a: return 8'h9f;
			'h405, 'h412: return 8'h1f;
			'h407: return 8'hdf;
			default: return 8'hff;
		endcase
	endfunction : fmask
	function automatic logic [7:0] csum(ilc_oct_arr_t c, logic m);
		int s;
		s = 0;
		if (m)
		begin
			for (int k = 0; k < 13; k++)
				s += c[k];
		end
		else
		begin
			s = c[0] + c[1][7:4] + c[1][3:0] + c[2][6] + c[2][5] + c[2][4:0] + c[3][7]
				+ c[3][4:0] + c[4] + c[5][4:0] + c[6] + c[7][7:6] + c[7][4:0] + c[8][7:5]
				+ c[8][4:0] + c[9][7:5] + c[9][4:0] + c[10][7] + c[10][4:0];
		end
		return 8'(s);
	endfunction : csum
	task automatic spi_xfer(logic rd, logic [14:0] adr, logic [7:0] wd, output logic [7:0] q);
		logic [23:0] sh;
		sh = {rd, adr, wd};
		q = 8'h00;
		spi.cs_b = 1'b0;
		for (int i = 0; i < 24; i++)
		begin
			spi.sclk = 1'b0;
			spi.sdi = sh[23 - i];
			tick(2);
			spi.sclk = 1'b1;
			tick(2);
			if (i >= 15 && i < 23)
			begin
				chk({7'h00, sdo_oe}, {7'h00, rd});
				q[22 - i] = sdo;
			end
		end
		spi.sclk = 1'b0;
		tick(2);
		spi.cs_b = 1'b1;
		tick(2);
	endtask : spi_xfer
	task automatic check_all(string tn);
		logic [7:0] d;
		for (int a = 'h403; a <= 'h412; a++)
		begin
			spi_xfer(1'b1, a[14:0], 8'h00, d);
			chk(d, mdl.exists(a) ? 8'(mdl[a]) : 8'h00);
		end
		$display("Test %s done, errors %0d", tn, num_errors);
	endtask : check_all
	task automatic send(int t, logic m);
		for (int k = 0; k < OCT_FCHK; k++)
			cfg[k] = 8'($urandom);
		cfg[OCT_SCR_L][4:0] = 5'((1 << t) - 1);
		mode = m;
		cfg[OCT_FCHK] = csum(cfg, m);
		lid = 8'($urandom);
		go = 1'b1;
		tick(1);
		go = 1'b0;
		while (busy)
			tick(1);
		tick(3);
	endtask : send
	task automatic load();
		for (int k = OCT_SCR_L; k <= OCT_RES2; k++)
			mdl['h400 + k] = cfg[k] & fmask('h400 + k);
		mdl['h40d] = cfg[OCT_FCHK];
		mdl['h40e] = csum(cfg, mode);
		mdl['h412] = lid & 'h1f;
	endtask : load
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			num_errors++;
			finish_test();
		end
	end
	initial
	begin
		logic [7:0] d;
		void'($urandom(32'hc80abc3d));
		tick(12);
		rst_b = 1'b1;
		check_all("reset");
		for (int t = 0; t < 4; t++)
		begin
			send(t, t[0]);
			load();
			check_all("capture");
		end
		spi_xfer(1'b0, 15'h0404, 8'h5a, d);
		check_all("write");
		ce = 1'b0;
		send(2, 1'b0);
		ce = 1'b1;
		check_all("hold");
		rst_b = 1'b0;
		tick(2);
		rst_b = 1'b1;
		mdl.delete();
		check_all("rereset");
		finish_test();
	end
endmodule : ilc_capture_test

// ---- tb/ilc_tx_model.sv ----
`timescale 1ns/10ps
module ilc_tx_model
	import ilc_pkg::*;
(
	// Clock and request
	input wire logic clk_in,
	input wire logic go_in,
	input wire ilc_oct_arr_t cfg_in,
	input wire logic [7:0] lid_in,
	// Lane streams
	output ilc_lane_t lane0_out,
	output ilc_lane_t lane1_out,
	output logic busy_out
);
	int n = CFG_OCTETS;
	logic [7:0] o;
	initial
	begin
		lane0_out = '0;
		lane1_out = '0;
	end
	// Random stalls; idle octets toggle so stale data is never mistaken for valid
	always @(posedge clk_in)
	begin
		if (go_in && n == CFG_OCTETS)
		begin
			n = 0;
		end
		#1;
		if (n < CFG_OCTETS && $urandom_range(3) != 0)
		begin
			// The checksum octet arrives in cfg_in, made with the receiver's method
			o = cfg_in[n];
			lane0_out = '{sof: n == 0, valid: 1'b1, octet: o};
			lane1_out = '{sof: n == 0, valid: 1'b1, octet: (n == OCT_LID) ? lid_in : o};
			n++;
		end
		else
		begin
			lane0_out = '{sof: 1'b0, valid: 1'b0, octet: ~lane0_out.octet};
			lane1_out = '{sof: 1'b0, valid: 1'b0, octet: ~lane1_out.octet};
		end
	end
	assign busy_out = n < CFG_OCTETS;
endmodule : ilc_tx_model

// ---- verilog/ilc_capture.sv ----
`timescale 1ns/10ps
module ilc_capture (
	// Clock, reset, enable
	input wire logic CORE_CLK_IN,
	input wire logic RST_B_IN,
	input wire logic CE_IN,
	// Lane receive octet streams
	input wire ilc_pkg::ilc_lane_t LANE0_IN,
	input wire ilc_pkg::ilc_lane_t LANE1_IN,
	// Checksum method select
	input wire logic CHECKSUM_MODE_IN,
	// Serial control port
	input wire ilc_pkg::ilc_spi_t SPI_IN,
	output wire logic SDO_OUT,
	output wire logic SDO_OE_OUT
);
	import ilc_pkg::*;

	//***********************************************
	// State
	//***********************************************
	typedef struct packed {
		ilc_cap_st_t cap_st;
		logic [3:0] cap_idx;
		ilc_oct_arr_t shadow;
		ilc_oct_arr_t cfg;
		logic [7:0] comp_sum;
		logic l1_act;
		logic [3:0] l1_idx;
		logic [7:0] l1_pend;
		logic [7:0] l1_lid;
		ilc_spi_st_t spi_st;
		logic [4:0] bit_cnt;
		logic [15:0] cmd;
		logic [7:0] rd_sh;
		logic sclk_q;
		logic sdo;
		logic sdo_oe;
	} ilc_state_t;

	ilc_state_t s_r;
	ilc_state_t s_nxt;
	logic [7:0] calc_sum;
	logic [15:0] cmd_full;
	logic [7:0] rd_val;
	logic rise;
	logic fall;

	//***********************************************
	// Register read decode
	//***********************************************
	function automatic logic [7:0] rd_reg(
		input logic [14:0] a,
		input ilc_oct_arr_t c,
		input logic [7:0] cs,
		input logic [7:0] lid
	);
		case (a)
			ADR_SCR_L:
			begin
				rd_reg = c[OCT_SCR_L] & (MSK_B7 | MSK_LO5);
			end
			ADR_F:
			begin
				rd_reg = c[OCT_F];
			end
			ADR_K:
			begin
				rd_reg = c[OCT_K] & MSK_LO5;
			end
			ADR_M:
			begin
				rd_reg = c[OCT_M];
			end
			ADR_CS_N:
			begin
				// Bit 5 is reserved and reads zero
				rd_reg = c[OCT_CS_N] & (MSK_HI2 | MSK_LO5);
			end
			ADR_NP:
			begin
				rd_reg = c[OCT_NP];
			end
			ADR_S:
			begin
				rd_reg = c[OCT_S];
			end
			ADR_HD_CF:
			begin
				rd_reg = c[OCT_HD_CF] & (MSK_B7 | MSK_LO5);
			end
			ADR_RES1:
			begin
				rd_reg = c[OCT_RES1];
			end
			ADR_RES2:
			begin
				rd_reg = c[OCT_RES2];
			end
			ADR_FCHK0:
			begin
				rd_reg = c[OCT_FCHK];
			end
			ADR_FCMP0:
			begin
				rd_reg = cs;
			end
			ADR_LID1:
			begin
				rd_reg = lid & MSK_LO5;
			end
			default:
			begin
				rd_reg = RST_OCTET;
			end
		endcase
	endfunction : rd_reg

	//***********************************************
	// Checksum over the collected octets
	//***********************************************
	// The sum is taken on the shadow, which is stable in the commit cycle
	ilc_checksum u_checksum (
		.cfg_in(s_r.shadow),
		.mode_in(CHECKSUM_MODE_IN),
		.sum_out(calc_sum)
	);

	assign rise = SPI_IN.sclk & ~s_r.sclk_q;
	assign fall = ~SPI_IN.sclk & s_r.sclk_q;
	assign cmd_full = {s_r.cmd[14:0], SPI_IN.sdi};
	assign rd_val = rd_reg(cmd_full[ADR_W-1:0], s_r.cfg, s_r.comp_sum, s_r.l1_lid);

	//***********************************************
	// Next state
	//***********************************************
	always_comb
	begin
		s_nxt = s_r;

		// Lane 0: collect into the shadow, publish only a complete set
		case (s_r.cap_st)
			CAP_WAIT:
			begin
				if (LANE0_IN.valid && LANE0_IN.sof)
				begin
					s_nxt.shadow[OCT_DID] = LANE0_IN.octet;
					s_nxt.cap_idx = 4'h1;
					s_nxt.cap_st = CAP_COLLECT;
				end
			end
			CAP_COLLECT:
			begin
				if (LANE0_IN.valid && LANE0_IN.sof)
				begin
					// A fresh start abandons the partial set
					s_nxt.shadow[OCT_DID] = LANE0_IN.octet;
					s_nxt.cap_idx = 4'h1;
				end
				else if (LANE0_IN.valid)
				begin
					s_nxt.shadow[s_r.cap_idx] = LANE0_IN.octet;
					if (s_r.cap_idx == 4'(OCT_FCHK))
					begin
						s_nxt.cap_st = CAP_COMMIT;
					end
					else
					begin
						s_nxt.cap_idx = s_r.cap_idx + 4'h1;
					end
				end
			end
			CAP_COMMIT:
			begin
				s_nxt.cfg = s_r.shadow;
				s_nxt.comp_sum = calc_sum;
				s_nxt.cap_st = CAP_WAIT;
			end
			default:
			begin
				s_nxt.cap_st = CAP_WAIT;
			end
		endcase

		// Lane 1: only the lane identifier is kept
		if (LANE1_IN.valid && LANE1_IN.sof)
		begin
			s_nxt.l1_act = 1'b1;
			s_nxt.l1_idx = 4'h1;
		end
		else if (LANE1_IN.valid && s_r.l1_act)
		begin
			if (s_r.l1_idx == 4'(OCT_LID))
			begin
				s_nxt.l1_pend = LANE1_IN.octet;
			end
			if (s_r.l1_idx == 4'(OCT_FCHK))
			begin
				s_nxt.l1_lid = s_r.l1_pend;
				s_nxt.l1_act = 1'b0;
			end
			else
			begin
				s_nxt.l1_idx = s_r.l1_idx + 4'h1;
			end
		end

		// Serial port: 16 command bits, then 8 data bits, MSB first
		s_nxt.sclk_q = SPI_IN.sclk;
		if (SPI_IN.cs_b)
		begin
			s_nxt.spi_st = SPI_IDLE;
			s_nxt.bit_cnt = 5'h00;
			s_nxt.sdo_oe = 1'b0;
			s_nxt.sdo = 1'b0;
		end
		else
		begin
			case (s_r.spi_st)
				SPI_IDLE, SPI_CMD:
				begin
					s_nxt.spi_st = SPI_CMD;
					if (rise)
					begin
						s_nxt.cmd = cmd_full;
						s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
						if (s_r.bit_cnt == CMD_LAST)
						begin
							s_nxt.bit_cnt = 5'h00;
							s_nxt.spi_st = SPI_DATA;
							// Writes are accepted on the wire but change nothing
							if (cmd_full[15])
							begin
								s_nxt.sdo_oe = 1'b1;
								s_nxt.sdo = rd_val[7];
								s_nxt.rd_sh = {rd_val[6:0], 1'b0};
							end
						end
					end
				end
				SPI_DATA:
				begin
					if (fall)
					begin
						s_nxt.sdo = s_r.rd_sh[7];
						s_nxt.rd_sh = {s_r.rd_sh[6:0], 1'b0};
					end
					if (rise)
					begin
						s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
						if (s_r.bit_cnt == DATA_LAST)
						begin
							s_nxt.spi_st = SPI_DONE;
						end
					end
				end
				SPI_DONE:
				begin
					// Let go after the last bit has been sampled
					if (fall)
					begin
						s_nxt.sdo_oe = 1'b0;
						s_nxt.sdo = 1'b0;
					end
				end
				default:
				begin
					s_nxt.spi_st = SPI_IDLE;
				end
			endcase
		end
	end

	//***********************************************
	// Registers
	//***********************************************
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (!RST_B_IN)
		begin
			s_r <= '0;
		end
		else if (CE_IN)
		begin
			s_r <= s_nxt;
		end
	end

	assign SDO_OUT = s_r.sdo;
	assign SDO_OE_OUT = s_r.sdo_oe;

	// Fields are stored whole as received; reads apply masks
endmodule : ilc_capture

// ---- verilog/ilc_checksum.sv ----
`timescale 1ns/10ps
module ilc_checksum (
	// Config octets and method
	input wire ilc_pkg::ilc_oct_arr_t cfg_in,
	input wire logic mode_in,
	// Result
	output logic [7:0] sum_out
);
	import ilc_pkg::*;

	function automatic logic [7:0] fld(input logic [7:0] o, input logic [7:0] m, input int sh);
		fld = (o & m) >> sh;
	endfunction : fld

	logic [7:0] fsum;
	logic [7:0] osum;

	//***********************************************
	// Field-wise and octet-wise sums
	//***********************************************
	always_comb
	begin
		osum = 8'h00;
		for (int i = 0; i < OCT_FCHK; i++)
		begin
			osum = osum + cfg_in[i];
		end
		// Spare octets carry no field, so the field-wise sum leaves them out
		fsum = cfg_in[OCT_DID] + fld(cfg_in[OCT_BID], MSK_HI4, SH_HI4)
			+ fld(cfg_in[OCT_BID], MSK_LO4, 0)
			+ fld(cfg_in[OCT_LID], MSK_B6, SH_B6) + fld(cfg_in[OCT_LID], MSK_B5, SH_B5)
			+ fld(cfg_in[OCT_LID], MSK_LO5, 0)
			+ fld(cfg_in[OCT_SCR_L], MSK_B7, SH_B7) + fld(cfg_in[OCT_SCR_L], MSK_LO5, 0)
			+ cfg_in[OCT_F] + fld(cfg_in[OCT_K], MSK_LO5, 0) + cfg_in[OCT_M]
			+ fld(cfg_in[OCT_CS_N], MSK_HI2, SH_HI2) + fld(cfg_in[OCT_CS_N], MSK_LO5, 0)
			+ fld(cfg_in[OCT_NP], MSK_HI3, SH_HI3) + fld(cfg_in[OCT_NP], MSK_LO5, 0)
			+ fld(cfg_in[OCT_S], MSK_HI3, SH_HI3) + fld(cfg_in[OCT_S], MSK_LO5, 0)
			+ fld(cfg_in[OCT_HD_CF], MSK_B7, SH_B7) + fld(cfg_in[OCT_HD_CF], MSK_LO5, 0);
		sum_out = (mode_in == MODE_FIELDS) ? fsum : osum;
	end
endmodule : ilc_checksum

// ---- verilog/ilc_pkg.sv ----
package ilc_pkg;
	//***********************************************
	// Summary of operation
	//***********************************************
	// Summary of operation
	// - Lane count field, 5 bits: 00000, 00001, 00011, 00111 for 1, 2, 4, 8 lanes.
	// - Octets per frame stored as value minus one; 1, 2 or 4 valid.
	// - Converter count stored minus one; 1 real, 2 complex.
	// - Control bits per sample held in bits 7:6; expected zero.
	// - Resolution minus one in bits 4:0; 16 bits reads 01111.
	// - Total bits per sample minus one in bits 4:0.
	// - Interface version in bits 7:5; 001 is revision B, A also encodable.
	// - Samples per converter per frame minus one in bits 4:0.
	// - Control words per frame in bits 4:0; expected zero.
	// - Both spare config octets of lane 0 readable as separate bytes.
	// - Checksum octet received on lane 0 is readable.
	// - Own checksum over lane 0 config, method picked by mode input.
	// - Transmitter uses the same method, so computed equals received.
	// - Lane identifier received on lane 1 is readable.
	// - Lane identifier in bits 4:0; bits 7:5 read zero.
	// - Scrambling flag in bit 7, beside the lane count field.

	//***********************************************
	// Config octet positions
	//***********************************************
	localparam int CFG_OCTETS = 14;
	localparam int OCT_DID = 0;
	localparam int OCT_BID = 1;
	localparam int OCT_LID = 2;
	localparam int OCT_SCR_L = 3;
	localparam int OCT_F = 4;
	localparam int OCT_K = 5;
	localparam int OCT_M = 6;
	localparam int OCT_CS_N = 7;
	localparam int OCT_NP = 8;
	localparam int OCT_S = 9;
	localparam int OCT_HD_CF = 10;
	localparam int OCT_RES1 = 11;
	localparam int OCT_RES2 = 12;
	localparam int OCT_FCHK = 13;

	//***********************************************
	// Field masks and shifts
	//***********************************************
	localparam logic [7:0] MSK_ALL = 8'hff;
	localparam logic [7:0] MSK_LO5 = 8'h1f;
	localparam logic [7:0] MSK_LO4 = 8'h0f;
	localparam logic [7:0] MSK_HI4 = 8'hf0;
	localparam logic [7:0] MSK_HI3 = 8'he0;
	localparam logic [7:0] MSK_HI2 = 8'hc0;
	localparam logic [7:0] MSK_B7 = 8'h80;
	localparam logic [7:0] MSK_B6 = 8'h40;
	localparam logic [7:0] MSK_B5 = 8'h20;
	localparam int SH_HI4 = 4;
	localparam int SH_HI3 = 5;
	localparam int SH_HI2 = 6;
	localparam int SH_B7 = 7;
	localparam int SH_B6 = 6;
	localparam int SH_B5 = 5;
	localparam logic [7:0] RST_OCTET = 8'h00;

	//***********************************************
	// Register map and serial port
	//***********************************************
	localparam int ADR_W = 15;
	localparam logic [14:0] ADR_SCR_L = 15'h0403;
	localparam logic [14:0] ADR_F = 15'h0404;
	localparam logic [14:0] ADR_K = 15'h0405;
	localparam logic [14:0] ADR_M = 15'h0406;
	localparam logic [14:0] ADR_CS_N = 15'h0407;
	localparam logic [14:0] ADR_NP = 15'h0408;
	localparam logic [14:0] ADR_S = 15'h0409;
	localparam logic [14:0] ADR_HD_CF = 15'h040a;
	localparam logic [14:0] ADR_RES1 = 15'h040b;
	localparam logic [14:0] ADR_RES2 = 15'h040c;
	localparam logic [14:0] ADR_FCHK0 = 15'h040d;
	localparam logic [14:0] ADR_FCMP0 = 15'h040e;
	localparam logic [14:0] ADR_LID1 = 15'h0412;
	localparam logic [4:0] CMD_LAST = 5'h0f;
	localparam logic [4:0] DATA_LAST = 5'h07;
	localparam logic MODE_FIELDS = 1'b0;

	//***********************************************
	// Types
	//***********************************************
	typedef logic [CFG_OCTETS-1:0][7:0] ilc_oct_arr_t;
	typedef struct packed {
		logic sof;
		logic valid;
		logic [7:0] octet;
	} ilc_lane_t;
	typedef struct packed {
		logic sclk;
		logic cs_b;
		logic sdi;
	} ilc_spi_t;
	typedef enum logic [1:0] {
		CAP_WAIT = 2'b00,
		CAP_COLLECT = 2'b01,
		CAP_COMMIT = 2'b11
	} ilc_cap_st_t;
	typedef enum logic [1:0] {
		SPI_IDLE = 2'b00,
		SPI_CMD = 2'b01,
		SPI_DATA = 2'b11,
		SPI_DONE = 2'b10
	} ilc_spi_st_t;
endpackage : ilc_pkg
